// ===== scmc_consts.svh
// Purpose: Constants for the system clock and mode control block
// Assumes: Byte registers on a plain strobe port
// Notes: Offsets, fields, reset values and timing counts
`ifndef SCMC_CONSTS_SVH
`define SCMC_CONSTS_SVH
`define SCMC_ADDR_W 3
`define SCMC_OFF_SYS_CLK_CTRL 3'h0
`define SCMC_OFF_FAST_OSC_CTRL 3'h1
`define SCMC_OFF_IRQ_STATUS 3'h2
`define SCMC_OFF_IRQ_MASK 3'h3
`define SCMC_OFF_MODE_STATUS 3'h4
`define SCMC_SEL_MSB 7
`define SCMC_SEL_LSB 5
`define SCMC_HS_KEEP_BIT 1
`define SCMC_LS_KEEP_BIT 0
`define SCMC_FREQ_MSB 3
`define SCMC_FREQ_LSB 2
`define SCMC_STABLE_BIT 1
`define SCMC_HS_EN_BIT 0
`define SCMC_SEL_LOW_SPEED 3'h7
`define SCMC_SYS_CLK_CTRL_RST 8'h00
`define SCMC_FREQ_RST 2'h0
`define SCMC_HS_EN_RST 1'b1
`define SCMC_SWITCH_BASE_PERIODS 4'h4
`define SCMC_DIV_W 6
`define SCMC_LS_SETTLE_W 4
`define SCMC_LS_SETTLE 4'h8
`endif

// ===== scmc_pkg.sv
// Purpose: Types for the system clock and mode control block
// Assumes: Used with scmc_consts.svh
// Notes: Types only
package scmc_pkg;
    typedef enum logic [2:0] {
        scmc_fast,
        scmc_slow,
        scmc_sleep,
        scmc_idle_low_speed_only,
        scmc_idle_dual_clock,
        scmc_idle_high_speed_only
    } scmc_mode_type;
    typedef enum logic [1:0] {
        scmc_sw_idle,
        scmc_sw_count,
        scmc_sw_wait_target
    } scmc_switch_type;
endpackage : scmc_pkg

// ===== scmc_system_clock_mode_control.sv
// Purpose: System clock source selection and low-power mode control
// Assumes: All oscillator clocks appear as enables/levels sampled on clk
// Notes: System clock leaves as a clock enable pulse, one per divided period
// Behaviour
// R1: Select codes 0-6 divide fast clock by 1..64; code 7 picks slow clock
// R2: Halt with both keep bits low enters sleep, stopping CPU and slow clock
// R3: In sleep the low RC clock runs only while watchdog is enabled
// R4: Halt with only slow keep bit high: CPU off, slow oscillator runs
// R5: Halt with both keep bits high: CPU off, both oscillators run
// R6: Halt with only fast keep bit high: CPU off, fast runs, slow stops
// R7: In slow mode the fast clock runs only while its enable bit is set; the code also runs it while a fast select code is written but not yet active
// R8: New source takes effect after four current periods plus target alignment
// R9: Frequency codes map 8,12,16,8 MHz; new value applies once stable
// R10: Enabling or refreshing frequency clears stable flag until oscillator settles
// R11: Fast oscillator enable starts or stops it; power-on value is one
// R12: Software should match frequency code to the one-time option
// R13: Switch to slow completes only after the low RC oscillator is stable
// R14: Software polls the stable flag before relying on a restarted fast clock
// R15: Sleep stops system clock and fetch; state is held unchanged
// R16: Halt sets power-down flag and clears watchdog timeout flag
// R17: Halt clears the watchdog counter; it resumes only if enabled
// R18: Unimplemented register bits read as zero
// R19: Source and divider changes happen only on clock boundaries, glitch-free
`include "scmc_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module scmc_system_clock_mode_control (
    input wire logic clk,
    input wire logic srst,
    input wire logic [`SCMC_ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    input wire logic halt_exec,
    input wire logic wake_event,
    input wire logic watchdog_function_en,
    input wire logic hs_rc_tick,
    input wire logic hs_rc_ready,
    input wire logic ls_rc_tick,
    input wire logic ls_rc_ready,
    output logic system_clock_out,
    output logic cpu_run,
    output logic high_speed_rc_osc_en,
    output logic [1:0] hs_freq_mhz_code,
    output logic low_speed_rc_osc_en,
    output logic low_rc_clock_en,
    output logic fast_periph_clk_en,
    output logic slow_periph_clk_en,
    output logic power_down_flag_set,
    output logic watchdog_timeout_flag_clr,
    output logic watchdog_counter_clr,
    output logic irq
);
    logic [2:0] sys_clk_select;
    logic hs_osc_keep_alive;
    logic ls_osc_keep_alive;
    logic [1:0] hs_rc_freq_select;
    logic [1:0] freq_applied;
    logic hs_rc_stable_flag;
    logic hs_rc_enable;
    logic [2:0] sel_active;
    logic [2:0] sel_target;
    logic [3:0] sw_count;
    logic [`SCMC_DIV_W-1:0] div_cnt;
    logic [`SCMC_LS_SETTLE_W-1:0] ls_settle;
    logic ls_stable;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic next_sys_tick;
    logic src_tick;
    logic div_hit;
    logic [`SCMC_DIV_W-1:0] div_mask;
    logic cpu_on;
    logic hs_need;
    logic ls_need;
    logic sw_done;
    scmc_pkg::scmc_mode_type mode;
    scmc_pkg::scmc_switch_type sw_state;

    // Control register writes
    always_ff @(posedge clk) begin
        if (srst) begin
            sys_clk_select <= 3'(`SCMC_SYS_CLK_CTRL_RST >> `SCMC_SEL_LSB);
            hs_osc_keep_alive <= 1'b0;
            ls_osc_keep_alive <= 1'b0;
            hs_rc_freq_select <= `SCMC_FREQ_RST;
            hs_rc_enable <= `SCMC_HS_EN_RST; // [R11]
        end else if (wr_en) begin
            if (addr == `SCMC_OFF_SYS_CLK_CTRL) begin
                sys_clk_select <= wdata[`SCMC_SEL_MSB:`SCMC_SEL_LSB];
                hs_osc_keep_alive <= wdata[`SCMC_HS_KEEP_BIT];
                ls_osc_keep_alive <= wdata[`SCMC_LS_KEEP_BIT];
            end
            if (addr == `SCMC_OFF_FAST_OSC_CTRL) begin
                hs_rc_freq_select <= wdata[`SCMC_FREQ_MSB:`SCMC_FREQ_LSB];
                hs_rc_enable <= wdata[`SCMC_HS_EN_BIT]; // [R11]
            end
        end
    end

    // Stable flag: cleared on enable or frequency write, set when oscillator ready
    always_ff @(posedge clk) begin
        if (srst) begin
            hs_rc_stable_flag <= 1'b0;
            freq_applied <= `SCMC_FREQ_RST;
        end else if (wr_en && addr == `SCMC_OFF_FAST_OSC_CTRL
                     && (wdata[`SCMC_HS_EN_BIT]
                         || wdata[`SCMC_FREQ_MSB:`SCMC_FREQ_LSB] != hs_rc_freq_select)) begin
            hs_rc_stable_flag <= 1'b0; // [R10]
        end else if (!high_speed_rc_osc_en) begin
            hs_rc_stable_flag <= 1'b0;
        end else if (hs_rc_ready && !hs_rc_stable_flag) begin
            hs_rc_stable_flag <= 1'b1; // [R10]
            freq_applied <= hs_rc_freq_select; // [R9]
        end
    end

    // Code 3 maps to the same frequency as code 0
    always_comb begin
        hs_freq_mhz_code = (freq_applied == 2'h3) ? 2'h0 : freq_applied; // [R9]
    end

    // Low RC settle counter after it starts
    always_ff @(posedge clk) begin
        if (srst || !low_speed_rc_osc_en) begin
            ls_settle <= '0;
        end else if (ls_rc_ready && ls_rc_tick && ls_settle != `SCMC_LS_SETTLE) begin
            ls_settle <= ls_settle + 4'h1;
        end
    end
    assign ls_stable = (ls_settle == `SCMC_LS_SETTLE);

    // Operating mode
    always_ff @(posedge clk) begin
        if (srst) begin
            mode <= scmc_pkg::scmc_fast;
        end else begin
            case (mode)
                scmc_pkg::scmc_fast, scmc_pkg::scmc_slow: begin
                    if (halt_exec) begin
                        case ({hs_osc_keep_alive, ls_osc_keep_alive})
                            2'b00: mode <= scmc_pkg::scmc_sleep; // [R2]
                            2'b01: mode <= scmc_pkg::scmc_idle_low_speed_only; // [R4]
                            2'b11: mode <= scmc_pkg::scmc_idle_dual_clock; // [R5]
                            default: mode <= scmc_pkg::scmc_idle_high_speed_only; // [R6]
                        endcase
                    end else begin
                        mode <= (sel_active == `SCMC_SEL_LOW_SPEED)
                            ? scmc_pkg::scmc_slow : scmc_pkg::scmc_fast;
                    end
                end
                default: begin
                    if (wake_event) begin
                        mode <= (sel_active == `SCMC_SEL_LOW_SPEED)
                            ? scmc_pkg::scmc_slow : scmc_pkg::scmc_fast;
                    end
                end
            endcase
        end
    end

    assign cpu_on = (mode == scmc_pkg::scmc_fast) || (mode == scmc_pkg::scmc_slow);

    // Oscillator needs per mode
    always_comb begin
        case (mode)
            scmc_pkg::scmc_fast: begin
                hs_need = hs_rc_enable || (sel_active != `SCMC_SEL_LOW_SPEED);
                ls_need = 1'b1;
            end
            scmc_pkg::scmc_slow: begin
                // A pending return to fast restarts the fast oscillator
                hs_need = hs_rc_enable || (sys_clk_select != `SCMC_SEL_LOW_SPEED); // [R7] [R14]
                ls_need = 1'b1;
            end
            scmc_pkg::scmc_idle_low_speed_only: begin
                hs_need = 1'b0; // [R4]
                ls_need = 1'b1;
            end
            scmc_pkg::scmc_idle_dual_clock: begin
                hs_need = 1'b1; // [R5]
                ls_need = 1'b1;
            end
            scmc_pkg::scmc_idle_high_speed_only: begin
                hs_need = 1'b1; // [R6]
                ls_need = 1'b0;
            end
            default: begin
                hs_need = 1'b0; // [R2]
                ls_need = 1'b0;
            end
        endcase
    end

    // Oscillator enables and peripheral clocks
    always_ff @(posedge clk) begin
        if (srst) begin
            high_speed_rc_osc_en <= 1'b1;
            low_speed_rc_osc_en <= 1'b1;
            low_rc_clock_en <= 1'b1;
            fast_periph_clk_en <= 1'b1;
            slow_periph_clk_en <= 1'b1;
            cpu_run <= 1'b1;
        end else begin
            high_speed_rc_osc_en <= hs_need;
            fast_periph_clk_en <= hs_need && hs_rc_stable_flag; // [R14]
            slow_periph_clk_en <= ls_need; // [R2]
            low_speed_rc_osc_en <= ls_need || watchdog_function_en;
            low_rc_clock_en <= (mode == scmc_pkg::scmc_sleep)
                ? watchdog_function_en : 1'b1; // [R3]
            cpu_run <= cpu_on; // [R15]
        end
    end

    // Halt side effects
    always_ff @(posedge clk) begin
        if (srst) begin
            power_down_flag_set <= 1'b0;
            watchdog_timeout_flag_clr <= 1'b0;
            watchdog_counter_clr <= 1'b0;
        end else begin
            power_down_flag_set <= halt_exec && cpu_on; // [R16]
            watchdog_timeout_flag_clr <= halt_exec && cpu_on; // [R16]
            watchdog_counter_clr <= halt_exec && cpu_on; // [R17]
        end
    end

    // Source switch sequencer
    always_ff @(posedge clk) begin
        if (srst) begin
            sw_state <= scmc_pkg::scmc_sw_idle;
            sel_active <= 3'h0;
            sel_target <= 3'h0;
            sw_count <= 4'h0;
        end else begin
            case (sw_state)
                scmc_pkg::scmc_sw_idle: begin
                    if (sys_clk_select != sel_active) begin
                        sel_target <= sys_clk_select;
                        sw_count <= 4'h0;
                        sw_state <= scmc_pkg::scmc_sw_count;
                    end
                end
                scmc_pkg::scmc_sw_count: begin
                    if (system_clock_out) begin
                        if (sw_count == `SCMC_SWITCH_BASE_PERIODS - 4'h1) begin
                            sw_state <= scmc_pkg::scmc_sw_wait_target; // [R8]
                        end else begin
                            sw_count <= sw_count + 4'h1; // [R8]
                        end
                    end
                end
                scmc_pkg::scmc_sw_wait_target: begin
                    if (sw_done) begin
                        sel_active <= sel_target; // [R19]
                        sw_state <= scmc_pkg::scmc_sw_idle;
                    end
                end
                default: sw_state <= scmc_pkg::scmc_sw_idle;
            endcase
        end
    end

    // Target must be running; slow needs stable low RC
    // Fast targets switch where every divider ends a period
    always_comb begin
        if (sel_target == `SCMC_SEL_LOW_SPEED) begin
            sw_done = ls_stable && ls_rc_tick; // [R13]
        end else begin
            sw_done = hs_rc_stable_flag && hs_rc_tick && div_cnt == '1; // [R19]
        end
    end

    // Divider for fast clock
    always_comb begin
        div_mask = `SCMC_DIV_W'((7'h1 << sel_active) - 7'h1); // [R1]
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            div_cnt <= '0;
        end else if (hs_rc_tick) begin
            div_cnt <= div_cnt + `SCMC_DIV_W'(1);
        end
    end

    always_comb begin
        div_hit = hs_rc_tick && ((div_cnt & div_mask) == div_mask);
        src_tick = (sel_active == `SCMC_SEL_LOW_SPEED) ? ls_rc_tick : div_hit; // [R1]
        next_sys_tick = src_tick && cpu_on; // [R15]
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            system_clock_out <= 1'b0;
        end else begin
            system_clock_out <= next_sys_tick;
        end
    end

    // Interrupt: halt entry, switch complete, fast oscillator stable
    always_ff @(posedge clk) begin
        if (srst) begin
            irq_status <= 3'h0;
            irq_mask <= 3'h0;
        end else begin
            irq_status <= ((rd_en && addr == `SCMC_OFF_IRQ_STATUS) ? 3'h0 : irq_status)
                | {hs_rc_ready && !hs_rc_stable_flag && high_speed_rc_osc_en,
                   sw_state == scmc_pkg::scmc_sw_wait_target && sw_done,
                   halt_exec && cpu_on};
            if (wr_en && addr == `SCMC_OFF_IRQ_MASK) begin
                irq_mask <= wdata[2:0];
            end
        end
    end
    assign irq = |(irq_status & irq_mask);

    // Read port
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= 8'h00;
        end else if (rd_en) begin
            case (addr)
                `SCMC_OFF_SYS_CLK_CTRL:
                    rdata <= {sys_clk_select, 3'h0, hs_osc_keep_alive, ls_osc_keep_alive}; // [R18]
                `SCMC_OFF_FAST_OSC_CTRL:
                    rdata <= {4'h0, hs_rc_freq_select, hs_rc_stable_flag, hs_rc_enable}; // [R18]
                `SCMC_OFF_IRQ_STATUS: rdata <= {5'h00, irq_status};
                `SCMC_OFF_IRQ_MASK: rdata <= {5'h00, irq_mask};
                `SCMC_OFF_MODE_STATUS: rdata <= {2'h0, sel_active, mode};
                default: rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end
endmodule : scmc_system_clock_mode_control
`default_nettype wire

// ===== scmc_system_clock_mode_control_monitor.sv
// Purpose: Port assertions for the clock and mode control block
// Assumes: One clock, srst synchronous active high
// Notes: Bound to the top module after the checker
`include "scmc_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module scmc_monitor (
    input wire logic clk,
    input wire logic srst,
    input wire logic [`SCMC_ADDR_W-1:0] addr,
    input wire logic rd_en,
    input wire logic [7:0] rdata,
    input wire logic halt_exec,
    input wire logic watchdog_function_en,
    input wire logic system_clock_out,
    input wire logic cpu_run,
    input wire logic high_speed_rc_osc_en,
    input wire logic [1:0] hs_freq_mhz_code,
    input wire logic low_rc_clock_en,
    input wire logic fast_periph_clk_en,
    input wire logic slow_periph_clk_en,
    input wire logic power_down_flag_set,
    input wire logic watchdog_timeout_flag_clr,
    input wire logic watchdog_counter_clr
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    // Accepted halt, then the sleep landing
    sequence s_halt;
        halt_exec && cpu_run && !$past(halt_exec);
    endsequence
    sequence s_sleep;
        s_halt ##2 (!fast_periph_clk_en && !slow_periph_clk_en);
    endsequence
    property p_halt_fx;
        s_halt |=> power_down_flag_set && watchdog_timeout_flag_clr;
    endproperty
    a_halt_fx: assert property (p_halt_fx) else $error("halt flags missing");
    property p_wdt_clr;
        power_down_flag_set |-> watchdog_counter_clr && $past(halt_exec);
    endproperty
    a_wdt_clr: assert property (p_wdt_clr) else $error("counter clear wrong");
    property p_halt_stop;
        s_halt |-> ##2 (!cpu_run && !system_clock_out);
    endproperty
    a_halt_stop: assert property (p_halt_stop) else $error("cpu still clocked");
    property p_sleep_low_speed_rc_osc;
        s_sleep |-> low_rc_clock_en == watchdog_function_en;
    endproperty
    a_sleep_low_speed_rc_osc: assert property (p_sleep_low_speed_rc_osc) else $error("low rc wrong in sleep");
    property p_sleep_clk;
        s_sleep |-> !system_clock_out [*3];
    endproperty
    a_sleep_clk: assert property (p_sleep_clk) else $error("clock in sleep");
    property p_idle_fast;
        s_halt ##2 (fast_periph_clk_en && !slow_periph_clk_en) |-> high_speed_rc_osc_en;
    endproperty
    a_idle_fast: assert property (p_idle_fast) else $error("fast rc off in idle");
    property p_freq;
        hs_freq_mhz_code != 2'h3
            && (!$changed(hs_freq_mhz_code) || $past(high_speed_rc_osc_en));
    endproperty
    a_freq: assert property (p_freq) else $error("bad frequency code");
    property p_sel_rsvd;
        rd_en && addr == `SCMC_OFF_SYS_CLK_CTRL |=> rdata[4:2] == 3'h0;
    endproperty
    a_sel_rsvd: assert property (p_sel_rsvd) else $error("reserved bits set");
endmodule : scmc_monitor
bind scmc_system_clock_mode_control scmc_monitor u_mon (.*);
`default_nettype wire

// ===== scmc_system_clock_mode_control_bench.sv
// Purpose: Self-checking bench for the clock and mode control block
// Assumes: Both RC clocks modelled as tick enables on clk
// Notes: Rows cover every select code, halts every keep pair
`include "scmc_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module scmc_system_clock_mode_control_bench;
    localparam logic [2:0] a_sys = `SCMC_OFF_SYS_CLK_CTRL;
    localparam logic [2:0] a_osc = `SCMC_OFF_FAST_OSC_CTRL;
    localparam logic [2:0] a_sts = `SCMC_OFF_IRQ_STATUS;
    localparam logic [2:0] a_msk = `SCMC_OFF_IRQ_MASK;
    localparam logic [2:0] a_mode = `SCMC_OFF_MODE_STATUS;
    logic clk = 1'h0, srst = 1'h1, wr_en = 1'h0, rd_en = 1'h0, halt_exec = 1'h0;
    logic wake_event = 1'h0, watchdog_function_en = 1'h0, hs_rc_tick = 1'h1;
    logic hs_rc_ready = 1'h0, ls_rc_tick = 1'h0, ls_rc_ready = 1'h1;
    logic [2:0] addr = 3'h0;
    logic [1:0] ls_cnt = 2'h0;
    logic [7:0] wdata = 8'h00, rdata, d, n;
    logic system_clock_out, cpu_run, high_speed_rc_osc_en, low_speed_rc_osc_en, irq;
    logic low_rc_clock_en, fast_periph_clk_en, slow_periph_clk_en, power_down_flag_set;
    logic watchdog_timeout_flag_clr, watchdog_counter_clr;
    logic [1:0] hs_freq_mhz_code;
    int failures = 0, num_checks = 0;
    // Select code beside clock pulses seen in 128 cycles
    logic [10:0] rows [0:7] = '{11'h080, 11'h140, 11'h220, 11'h310, 11'h408, 11'h504,
        11'h602, 11'h720};
    // Mode, keep bits, {cpu, clock, fast, slow, low rc, irq, 00}
    logic [12:0] hrow [0:4] = '{13'h0804, 13'h0d1c, 13'h162c, 13'h133c, 13'h0808};
    wire logic [7:0] fx = {5'h0, power_down_flag_set, watchdog_timeout_flag_clr,
        watchdog_counter_clr};
    wire logic [7:0] outs = {cpu_run, system_clock_out, fast_periph_clk_en,
        slow_periph_clk_en, low_rc_clock_en, irq, 2'h0};
    scmc_system_clock_mode_control u_dut (.*);
    initial begin
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        ls_cnt <= ls_cnt + 2'h1;
        ls_rc_tick <= (ls_cnt == 2'h3);
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_en <= 1'h1;
        @(posedge clk);
        wr_en <= 1'h0;
    endtask : wr
    task automatic rd(input logic [2:0] a);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'h1;
        @(posedge clk);
        rd_en <= 1'h0;
        #1;
        d = rdata;
    endtask : rd
    task automatic rdc(input logic [2:0] a, input logic [7:0] exp, input string what);
        rd(a);
        chk(what, exp, d);
    endtask : rdc
    task automatic wait_sel(input logic [2:0] s);
        d = {2'h0, ~s, 3'h0};
        for (int k = 0; k < 400 && d[5:3] !== s; k++) begin
            rd(a_mode);
        end
        rd(a_mode);
    endtask : wait_sel
    task automatic end_sim;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim
    initial begin
        #100000;
        failures++;
        $display("Error run_time expected done seen timeout");
        end_sim();
    end
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'h0;
        rdc(a_sys, 8'h00, "sys_reset");
        rdc(a_osc, 8'h01, "osc_reset");
        chk("osc_en", 8'h01, {7'h0, high_speed_rc_osc_en});
        @(posedge clk);
        #1;
        chk("rdata_idle", 8'h00, rdata);
        wr(3'h7, 8'hff);
        rdc(3'h7, 8'h00, "unmapped");
        @(posedge clk);
        hs_rc_ready <= 1'h1;
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            wr(a_sys, {rows[i][10:8], 5'h00});
            rdc(a_mode, {2'h0, rows[(i == 0) ? 0 : i - 1][10:8], 3'h0}, "early");
            wait_sel(rows[i][10:8]);
            chk("mode", {2'h0, rows[i][10:8], 2'h0, rows[i][10:8] == 3'h7}, d);
            n = 8'h00;
            repeat (128) begin
                @(negedge clk);
                n = n + {7'h0, system_clock_out};
            end
            chk("pulses", rows[i][7:0], n);
        end
        $display("test select done");
        wr(a_osc, 8'h00);
        repeat (3) @(posedge clk);
        #1;
        chk("hs_off", 8'h00, {6'h0, high_speed_rc_osc_en, fast_periph_clk_en});
        for (int f = 0; f < 4; f++) begin
            wr(a_osc, {4'hf, f[1:0] ^ 2'h2, 2'h3});
            repeat (3) @(posedge clk);
            rdc(a_osc, {4'h0, f[1:0] ^ 2'h2, 2'h3}, "osc_fields");
            chk("freq", {6'h0, (f[1:0] ^ 2'h2) & {2{f != 1}}}, {6'h0, hs_freq_mhz_code});
        end
        chk("hs_on", 8'h03, {6'h0, high_speed_rc_osc_en, fast_periph_clk_en});
        @(posedge clk);
        hs_rc_ready <= 1'h0;
        wr(a_osc, 8'h09);
        rdc(a_osc, 8'h09, "stable_clear");
        chk("freq_held", 8'h01, {6'h0, hs_freq_mhz_code});
        @(posedge clk);
        hs_rc_ready <= 1'h1;
        repeat (3) @(posedge clk);
        rdc(a_osc, 8'h0b, "stable_set");
        chk("freq_new", 8'h02, {6'h0, hs_freq_mhz_code});
        wr(a_osc, 8'h08);
        wr(a_sys, 8'h1f);
        rdc(a_sys, 8'h03, "sys_rsvd");
        wait_sel(3'h0);
        chk("to_fast", 8'h00, d);
        $display("test oscillator done");
        for (int i = 0; i < 5; i++) begin
            wr(a_sys, {6'h0, hrow[i][9:8]});
            wr(a_msk, {7'h0, i < 4});
            watchdog_function_en <= (i == 4);
            rd(a_sts);
            @(posedge clk);
            halt_exec <= 1'h1;
            @(posedge clk);
            halt_exec <= 1'h0;
            #1;
            chk("halt_fx", 8'h07, fx);
            @(posedge clk);
            #1;
            chk("halt_outs", hrow[i][7:0], outs);
            chk("ls_osc", {7'h0, hrow[i][4] || i == 4}, {7'h0, low_speed_rc_osc_en});
            rdc(a_mode, {5'h0, hrow[i][12:10]}, "halt_mode");
            rd(a_sts);
            chk("halt_status", 8'h01, d & 8'h01);
            chk("irq_clear", 8'h00, {7'h0, irq});
            @(posedge clk);
            wake_event <= 1'h1;
            @(posedge clk);
            wake_event <= 1'h0;
            for (int k = 0; k < 100 && cpu_run !== 1'h1; k++) @(posedge clk);
        end
        $display("test halt done");
        end_sim();
    end
endmodule : scmc_system_clock_mode_control_bench
`default_nettype wire
